// ===== rtl/trig_top.sv
// trigger control top: AXI4-Lite registers, connector mapping and two channel sequencers
//
// Our own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
`include "trig_params.svh"
// How it works
// R01: continuous mode: after one accepted trigger, sequence repeats with no more triggers.
// R02: single mode: each accepted trigger plays exactly one pass, then stops.
// R03: gate mode: sequence repeats while gate is active, halts when inactive.
// R04: gate active level selectable high or low.
// R05: a control bit selects manual key or external pin as trigger source.
// R06: external source takes edges from connector assigned to that channel.
// R07: manual source: an execute write counts as one trigger event.
// R08: slope bit picks rising or falling edge for external trigger.
// R09: delay enable off means external edge acts without added delay.
// R10: delay on postpones external trigger by time or sample count.
// R11: continuous mode has auto, triggered and realtime sub-types.
// R12: dual variant has four connectors, two shared; single variant has one shared.
// R13: connectors two and four are marker outputs of their selected channel.
// R14: connector one is trigger A only when assigned to channel A, else marker one.
// R15: connector three is trigger B only when assigned to channel B, else marker three.
// R16: during a single pass extra triggers are ignored until the pass ends.
module trig_top (
   input wire logic aclk, // clock, 20 MHz
   input wire logic aresetn, // sync reset, active low
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // byte enables
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   input wire logic [3:0] conn_in, // connector pin levels
   output logic [3:0] conn_out, // connector drive levels
   output logic [3:0] conn_oe, // connector output enables
   input wire logic gate_a, // gate input channel A
   input wire logic gate_b, // gate input channel B
   output logic [1:0] run_out // channel generating, bit0 A
);
   logic [31:0] ctrl_q [2];
   logic [31:0] dly_q [2];
   logic [31:0] len_q [2];
   logic [31:0] conn_q;
   logic [1:0] exec_q;
   logic aw_q, w_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic [31:0] rd_d;
   logic [1:0] mk;
   logic trig_a_sel, trig_b_sel;
   logic do_wr;
   trig_cfg_if cfg_a ();
   trig_cfg_if cfg_b ();

   // ------------------------------------------------------------------
   // connector mapping
   // ------------------------------------------------------------------
   // single-channel build has no connector three input path
   assign trig_a_sel = conn_q[`F_CONN1_TRIG] & ~conn_q[`F_CONN1_CH]; // [R12] [R14]
   assign trig_b_sel = `DUAL_CHANNEL & conn_q[`F_CONN3_TRIG] & conn_q[`F_CONN3_CH]; // [R12] [R15]
   assign mk = {cfg_b.marker, cfg_a.marker};
   assign cfg_a.trig_in = trig_a_sel & conn_in[0]; // [R06]
   assign cfg_b.trig_in = trig_b_sel & conn_in[2]; // [R06]
   assign cfg_a.gate_in = gate_a;
   assign cfg_b.gate_in = gate_b;
   assign cfg_a.ctrl = ctrl_q[0];
   assign cfg_b.ctrl = ctrl_q[1];
   assign cfg_a.dly = dly_q[0];
   assign cfg_b.dly = dly_q[1];
   assign cfg_a.len = len_q[0];
   assign cfg_b.len = len_q[1];
   assign cfg_a.exec = exec_q[0];
   assign cfg_b.exec = exec_q[1];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         conn_out <= 4'h0;
         conn_oe <= 4'h0;
         run_out <= 2'h0;
      end else begin
         conn_out[0] <= mk[conn_q[`F_CONN1_CH]] & ~trig_a_sel; // [R14]
         conn_oe[0] <= ~trig_a_sel; // [R14]
         conn_out[1] <= mk[conn_q[`F_CONN2_CH]]; // [R13]
         conn_oe[1] <= 1'b1; // [R13]
         conn_out[2] <= mk[conn_q[`F_CONN3_CH]] & ~trig_b_sel; // [R15]
         conn_oe[2] <= ~trig_b_sel; // [R15]
         conn_out[3] <= mk[conn_q[`F_CONN4_CH]]; // [R13]
         conn_oe[3] <= 1'b1; // [R13]
         run_out <= {cfg_b.running, cfg_a.running};
      end
   end

   AST_CONN1_INPUT: assert property (@(posedge aclk) disable iff (!aresetn) // [R14]
      conn_q[`F_CONN1_CH] |=> conn_oe[0]) else $error("conn1 input on B");
   // gated by the sampled reset so the attempt at the release edge stays quiet
   AST_CONN24_DRIVE: assert property (@(posedge aclk) disable iff (!aresetn) // [R13]
      aresetn |=> conn_oe[1] && conn_oe[3]
      && conn_out[1] == $past(mk[conn_q[`F_CONN2_CH]])
      && conn_out[3] == $past(mk[conn_q[`F_CONN4_CH]]))
      else $error("marker-only connector not driven");

   // ------------------------------------------------------------------
   // axi4-lite slave
   // ------------------------------------------------------------------
   assign do_wr = aw_q & w_q & ~s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else begin
         s_axi_awready <= ~aw_q & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready <= ~w_q & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awready && s_axi_awvalid) begin
            aw_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wready && s_axi_wvalid) begin
            w_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (do_wr) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_q > `OFS_EXEC || awaddr_q[1:0] != 2'h0) ? 2'h2 : 2'h0;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // a write of bit0/bit1 to the execute register pulses the manual trigger
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q[0] <= `CTRL_RST;
         ctrl_q[1] <= `CTRL_RST;
         dly_q[0] <= 32'h0;
         dly_q[1] <= 32'h0;
         len_q[0] <= `LEN_RST;
         len_q[1] <= `LEN_RST;
         conn_q <= `CONN_RST;
         exec_q <= 2'h0;
      end else begin
         exec_q <= 2'h0;
         if (do_wr && wstrb_q[0]) begin
            case (awaddr_q)
               `OFS_CTRL_A: ctrl_q[0] <= wdata_q; // [R05] [R08] [R04] [R09] [R11]
               `OFS_CTRL_B: ctrl_q[1] <= wdata_q;
               `OFS_DLY_A: dly_q[0] <= wdata_q; // [R10]
               `OFS_DLY_B: dly_q[1] <= wdata_q;
               `OFS_LEN_A: len_q[0] <= (wdata_q == 32'h0) ? 32'h1 : wdata_q;
               `OFS_LEN_B: len_q[1] <= (wdata_q == 32'h0) ? 32'h1 : wdata_q;
               `OFS_CONN: conn_q <= wdata_q;
               `OFS_EXEC: exec_q <= wdata_q[1:0]; // [R07]
               default: exec_q <= 2'h0;
            endcase
         end
      end
   end

   always_comb begin
      case (s_axi_araddr)
         `OFS_CTRL_A: rd_d = ctrl_q[0];
         `OFS_CTRL_B: rd_d = ctrl_q[1];
         `OFS_DLY_A: rd_d = dly_q[0];
         `OFS_DLY_B: rd_d = dly_q[1];
         `OFS_LEN_A: rd_d = len_q[0];
         `OFS_LEN_B: rd_d = len_q[1];
         `OFS_CONN: rd_d = conn_q;
         `OFS_STAT: rd_d = {28'h0, cfg_b.armed, cfg_a.armed, cfg_b.running, cfg_a.running};
         default: rd_d = 32'h0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'h0;
      end else begin
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
         if (s_axi_arready && s_axi_arvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_d;
            s_axi_rresp <= (s_axi_araddr > `OFS_STAT || s_axi_araddr[1:0] != 2'h0) ? 2'h2 : 2'h0;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // channels
   // ------------------------------------------------------------------
   trig_chan chan_a (
      .aclk(aclk),
      .aresetn(aresetn),
      .cfg(cfg_a)
   );
   trig_chan chan_b (
      .aclk(aclk),
      .aresetn(aresetn),
      .cfg(cfg_b)
   );
endmodule

// ===== rtl/trig_params.svh
// timing constants, register offsets, field positions and reset values for the trigger control
`ifndef TRIG_PARAMS_SVH
`define TRIG_PARAMS_SVH
`define OFS_CTRL_A 8'h00
`define OFS_CTRL_B 8'h04
`define OFS_DLY_A 8'h08
`define OFS_DLY_B 8'h0c
`define OFS_LEN_A 8'h10
`define OFS_LEN_B 8'h14
`define OFS_CONN 8'h18
`define OFS_STAT 8'h1c
`define OFS_EXEC 8'h20
`define F_MODE 0
`define F_CTYPE 2
`define F_SRC 4
`define F_SLOPE 5
`define F_GATE_LOW 6
`define F_DLY_EN 7
`define F_DLY_UNIT 8
`define F_RUN 9
`define F_CONN1_CH 0
`define F_CONN1_TRIG 1
`define F_CONN2_CH 2
`define F_CONN3_CH 3
`define F_CONN3_TRIG 4
`define F_CONN4_CH 5
`define CTRL_RST 32'h0000_0000
`define CONN_RST 32'h0000_000c
`define LEN_RST 32'h0000_0010
`define SAMPLE_NS 50
`define CLK_NS 50
`define DUAL_CHANNEL 1'b1
`endif

// ===== rtl/trig_pkg.sv
// shared types for the trigger control
package trig_pkg;
   typedef enum logic [1:0] {
      mode_cont = 2'h0,
      mode_single = 2'h1,
      mode_gate = 2'h2
   } mode_type;
   typedef enum logic [1:0] {
      cont_auto = 2'h0,
      cont_trig = 2'h1,
      cont_realtime = 2'h2
   } cont_type;
   typedef enum logic [3:0] {
      st_idle = 4'h1,
      st_wait = 4'h2,
      st_run = 4'h4,
      st_gate = 4'h8
   } state_type;
endpackage

// ===== rtl/trig_cfg_if.sv
// per-channel configuration carried from the register file to a channel sequencer
`timescale 1ns/10ps
interface trig_cfg_if;
   logic [31:0] ctrl;
   logic [31:0] dly;
   logic [31:0] len;
   logic exec;
   logic trig_in;
   logic gate_in;
   logic running;
   logic marker;
   logic armed;
   modport regs (output ctrl, output dly, output len, output exec, output trig_in,
      output gate_in, input running, input marker, input armed);
   modport seq (input ctrl, input dly, input len, input exec, input trig_in,
      input gate_in, output running, output marker, output armed);
endinterface

// ===== rtl/trig_chan.sv
// one channel: trigger qualification, delay and play-out sequencing
`timescale 1ns/10ps
`include "trig_params.svh"
module trig_chan (
   input wire logic aclk, // clock
   input wire logic aresetn, // sync reset, active low
   trig_cfg_if.seq cfg // configuration and status
);
   trig_pkg::state_type state_q;
   trig_pkg::mode_type mode;
   logic trig_prev_q;
   logic ext_edge, key_ev, trig_ev, gate_ok, pass_end;
   logic [31:0] dly_q, dly_cycles, pos_q;
   localparam logic [31:0] SAMPLE_CYC = 32'(`SAMPLE_NS / `CLK_NS);

   assign mode = trig_pkg::mode_type'(cfg.ctrl[`F_MODE +: 2]);
   // rising or falling edge chosen by slope
   assign ext_edge = cfg.ctrl[`F_SLOPE] ? (trig_prev_q & ~cfg.trig_in)
      : (~trig_prev_q & cfg.trig_in); // [R08]
   assign key_ev = ~cfg.ctrl[`F_SRC] & cfg.exec; // [R05] [R07]
   assign trig_ev = cfg.ctrl[`F_SRC] ? ext_edge : key_ev; // [R05] [R06]
   assign gate_ok = cfg.gate_in ^ cfg.ctrl[`F_GATE_LOW]; // [R04]
   // delay in ns when unit bit low, in samples when high
   assign dly_cycles = cfg.ctrl[`F_DLY_UNIT] ? cfg.dly * SAMPLE_CYC
      : cfg.dly / `CLK_NS; // [R10]
   assign pass_end = (pos_q == cfg.len - 32'h1);
   assign cfg.running = (state_q == trig_pkg::st_run) | (state_q == trig_pkg::st_gate);
   assign cfg.marker = cfg.running & (pos_q == 32'h0);
   assign cfg.armed = (state_q == trig_pkg::st_idle);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trig_prev_q <= 1'b0;
      end else begin
         trig_prev_q <= cfg.trig_in;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pos_q <= 32'h0;
      end else if (!cfg.running || pass_end) begin
         pos_q <= 32'h0;
      end else begin
         pos_q <= pos_q + 32'h1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= trig_pkg::st_idle;
         dly_q <= 32'h0;
      end else if (!cfg.ctrl[`F_RUN]) begin
         state_q <= trig_pkg::st_idle;
      end else begin
         case (state_q)
            trig_pkg::st_idle: begin
               if (mode == trig_pkg::mode_gate) begin
                  if (gate_ok) state_q <= trig_pkg::st_gate; // [R03]
               end else if (mode == trig_pkg::mode_cont
                  && cfg.ctrl[`F_CTYPE +: 2] == trig_pkg::cont_auto) begin
                  state_q <= trig_pkg::st_run; // [R11]
               end else if (trig_ev) begin
                  if (cfg.ctrl[`F_SRC] && cfg.ctrl[`F_DLY_EN] && dly_cycles != 32'h0) begin
                     dly_q <= dly_cycles - 32'h1; // [R10]
                     state_q <= trig_pkg::st_wait;
                  end else begin
                     state_q <= trig_pkg::st_run; // [R09]
                  end
               end
            end
            trig_pkg::st_wait: begin
               if (dly_q == 32'h0) state_q <= trig_pkg::st_run;
               else dly_q <= dly_q - 32'h1;
            end
            trig_pkg::st_run: begin
               // single stops after one pass, ignoring triggers meanwhile
               if (mode == trig_pkg::mode_single && pass_end) begin
                  state_q <= trig_pkg::st_idle; // [R02] [R16]
               end // continuous stays here with no further trigger [R01]
            end
            trig_pkg::st_gate: begin
               if (!gate_ok || mode != trig_pkg::mode_gate) state_q <= trig_pkg::st_idle; // [R03]
            end
            default: state_q <= trig_pkg::st_idle;
         endcase
      end
   end

   sequence s_single_last;
      state_q == trig_pkg::st_run && mode == trig_pkg::mode_single && pass_end
         && cfg.ctrl[`F_RUN];
   endsequence
   AST_SINGLE_STOPS: assert property (@(posedge aclk) disable iff (!aresetn) // [R02]
      s_single_last |=> state_q == trig_pkg::st_idle) else $error("single pass did not stop");
   AST_SINGLE_IGNORES: assert property (@(posedge aclk) disable iff (!aresetn) // [R16]
      state_q == trig_pkg::st_run && mode == trig_pkg::mode_single && !pass_end
      && cfg.ctrl[`F_RUN] |=> state_q == trig_pkg::st_run) else $error("single pass cut short");
   AST_CONT_HOLDS: assert property (@(posedge aclk) disable iff (!aresetn) // [R01]
      state_q == trig_pkg::st_run && mode == trig_pkg::mode_cont && cfg.ctrl[`F_RUN]
      |=> state_q == trig_pkg::st_run) else $error("continuous play stopped");
   AST_GATE_HALT: assert property (@(posedge aclk) disable iff (!aresetn) // [R03]
      state_q == trig_pkg::st_gate && !gate_ok |=> !cfg.running) else $error("gate not halted");
   AST_KEY_START: assert property (@(posedge aclk) disable iff (!aresetn) // [R07]
      state_q == trig_pkg::st_idle && key_ev && cfg.ctrl[`F_RUN] && mode == trig_pkg::mode_single
      |=> state_q == trig_pkg::st_run) else $error("manual trigger not taken");
   AST_NO_DELAY: assert property (@(posedge aclk) disable iff (!aresetn) // [R09]
      state_q == trig_pkg::st_idle && ext_edge && cfg.ctrl[`F_SRC] && !cfg.ctrl[`F_DLY_EN]
      && cfg.ctrl[`F_RUN] && mode == trig_pkg::mode_single |=> cfg.running)
      else $error("undelayed edge not immediate");
   AST_DELAY_WAIT: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
      state_q == trig_pkg::st_wait && dly_q != 32'h0 && cfg.ctrl[`F_RUN]
      |=> state_q == trig_pkg::st_wait) else $error("delay ended early");
   AST_EXT_IGNORES_KEY: assert property (@(posedge aclk) disable iff (!aresetn) // [R05]
      state_q == trig_pkg::st_idle && cfg.ctrl[`F_SRC] && cfg.exec && !ext_edge
      && cfg.ctrl[`F_RUN] && mode == trig_pkg::mode_single |=> state_q == trig_pkg::st_idle)
      else $error("key taken with external source");
endmodule

// ===== verification/trig_source_model.sv
// far-side model: external trigger source sharing the rear connectors with the markers
`timescale 1ns/10ps
module trig_source_model (
   input wire logic aclk, // clock
   input wire logic [3:0] conn_out, // marker drive levels
   input wire logic [3:0] conn_oe, // marker output enables
   output logic [3:0] conn_in // resolved pin levels
);
   logic [3:0] src_q = 4'h0;
   // a driven pin shows its marker; a released one shows the source, never a stale marker
   assign conn_in = (conn_oe & conn_out) | (~conn_oe & src_q);
   // levels move just after an edge, so the slope seen depends only on the order of calls
   task automatic drive(input int idx, input logic lvl);
      @(posedge aclk);
      src_q[idx] <= lvl;
   endtask
endmodule

// ===== verification/baseband_trigger_control_test.sv
// self-checking testbench for the baseband trigger control
`timescale 1ns/10ps
`include "trig_params.svh"
module baseband_trigger_control_test;
   localparam logic [31:0] run_bit = 32'h1 << `F_RUN;
   localparam logic [31:0] ext_bit = 32'h1 << `F_SRC;
   localparam logic [31:0] fall_bit = 32'h1 << `F_SLOPE;
   localparam logic [31:0] low_bit = 32'h1 << `F_GATE_LOW;
   localparam logic [31:0] dly_bit = 32'h1 << `F_DLY_EN;
   localparam logic [31:0] single_m = 32'(trig_pkg::mode_single) << `F_MODE;
   localparam logic [31:0] gate_m = 32'(trig_pkg::mode_gate) << `F_MODE;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, gate_a, gate_b;
   logic awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp, run_out;
   logic [3:0] conn_in, conn_out, conn_oe;
   logic [1:0] last_bresp;
   int failures = 0;
   int compares = 0;
   int run_cnt = 0;
   trig_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .conn_in(conn_in), .conn_out(conn_out), .conn_oe(conn_oe),
      .gate_a(gate_a), .gate_b(gate_b), .run_out(run_out));
   trig_source_model src (.aclk(aclk), .conn_out(conn_out), .conn_oe(conn_oe),
      .conn_in(conn_in));
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   // free-running count of cycles with channel A generating; scenarios take differences
   always @(posedge aclk) begin
      if (run_out[0] === 1'b1) run_cnt <= run_cnt + 1;
   end
   // ----------------------------------------
   // checking and bus helpers
   // ----------------------------------------
   task automatic tally_and_finish;
      if (failures == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         failures++;
      end
   endtask
   task automatic hang;
      chk(32'h0, 32'h1);
      tally_and_finish();
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         n++;
         if (n > 50) hang();
      end while (bvalid !== 1'b1);
      last_bresp = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
         n++;
         if (n > 50) hang();
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   task automatic wait_run(input logic v, input int lim, output int c);
      c = 0;
      while (run_out[0] !== v) begin
         @(posedge aclk);
         c++;
         if (c > lim) hang();
      end
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic s_reset;
      logic [31:0] d;
      logic [1:0] r;
      cyc(2);
      chk(conn_oe, 4'hf);
      chk(run_out, 2'h0);
      rd(`OFS_CONN, d, r);
      chk(d, `CONN_RST);
      rd(`OFS_LEN_A, d, r);
      chk(d, `LEN_RST);
      rd(8'h24, d, r);
      chk(r, 2'h2);
      wr(8'h24, 32'h0);
      chk(last_bresp, 2'h2);
   endtask
   task automatic s_map;
      logic [5:0] cv [5] = '{6'h0c, 6'h0e, 6'h0f, 6'h1c, 6'h14};
      logic [3:0] oe [5] = '{4'hf, 4'he, 4'hf, 4'hb, 4'hf};
      for (int i = 0; i < 5; i++) begin
         wr(`OFS_CONN, 32'(cv[i]));
         chk(last_bresp, 2'h0);
         cyc(2);
         chk(conn_oe, oe[i]);
      end
   endtask
   task automatic s_single;
      logic [31:0] d;
      logic [1:0] r;
      int c;
      int c0;
      wr(`OFS_LEN_A, 32'd40);
      wr(`OFS_CTRL_A, single_m | run_bit);
      c0 = run_cnt;
      wr(`OFS_EXEC, 32'h1);
      wait_run(1'b1, 10, c);
      rd(`OFS_STAT, d, r);
      chk(d, 32'h9);
      wr(`OFS_EXEC, 32'h1);
      wait_run(1'b0, 60, c);
      chk(run_cnt - c0, 40);
      cyc(10);
      chk(run_out[0], 1'b0);
   endtask
   task automatic s_cont;
      int c;
      int c0;
      int m0;
      int m3;
      wr(`OFS_LEN_A, 32'd4);
      for (int t = 0; t < 3; t++) begin
         wr(`OFS_CTRL_A, 32'h0);
         cyc(3);
         wr(`OFS_CTRL_A, (32'(t) << `F_CTYPE) | run_bit);
         cyc(10);
         chk(run_out[0], t == 0);
         wr(`OFS_EXEC, 32'h1);
         wait_run(1'b1, 10, c);
         c0 = run_cnt;
         cyc(30);
         chk(run_cnt - c0, 30);
      end
      // channel B stays idle, so a connector mapped to it must stay quiet
      wr(`OFS_CONN, 32'h08);
      c = 0;
      while (conn_out[1] !== 1'b1) begin
         cyc(1);
         c++;
         if (c > 20) hang();
      end
      wr(`OFS_CONN, 32'h0c);
      cyc(2);
      c = 0;
      m0 = 0;
      m3 = 0;
      repeat (20) begin
         cyc(1);
         if (conn_out[1] === 1'b1 || conn_out[2] === 1'b1) c++;
         if (conn_out[0] === 1'b1) m0++;
         if (conn_out[3] === 1'b1) m3++;
      end
      chk(c, 0);
      chk(m0, 5);
      chk(m3, 5);
   endtask
   task automatic s_ext;
      int l0, l, c;
      wr(`OFS_CTRL_A, 32'h0);
      src.drive(0, 1'b0);
      wr(`OFS_CONN, 32'h0e);
      wr(`OFS_CTRL_A, single_m | ext_bit | run_bit);
      wr(`OFS_EXEC, 32'h1);
      cyc(10);
      chk(run_out[0], 1'b0);
      src.drive(0, 1'b1);
      wait_run(1'b1, 10, l0);
      chk(l0, 3);
      wait_run(1'b0, 20, c);
      wr(`OFS_CTRL_A, single_m | ext_bit | fall_bit | run_bit);
      src.drive(0, 1'b0);
      wait_run(1'b1, 10, l);
      chk(l, l0);
      wait_run(1'b0, 20, c);
      src.drive(0, 1'b1);
      cyc(10);
      chk(run_out[0], 1'b0);
      for (int u = 0; u < 2; u++) begin
         wr(`OFS_DLY_A, (u == 1) ? 32'd20 : 32'd1000);
         wr(`OFS_CTRL_A, single_m | ext_bit | fall_bit | dly_bit | (32'(u) << `F_DLY_UNIT)
            | run_bit);
         src.drive(0, 1'b0);
         wait_run(1'b1, 60, l);
         chk(l - l0, 20);
         wait_run(1'b0, 20, c);
         src.drive(0, 1'b1);
      end
      // channel A is stopped first so dropping its trigger pin cannot fake a falling edge
      wr(`OFS_CTRL_A, 32'h0);
      wr(`OFS_CONN, 32'h1c);
      wr(`OFS_CTRL_B, single_m | ext_bit | run_bit);
      src.drive(2, 1'b1);
      cyc(3);
      chk(run_out, 2'h2);
   endtask
   task automatic s_gate;
      int c;
      int c0;
      wr(`OFS_CTRL_A, 32'h0);
      wr(`OFS_CTRL_A, gate_m | run_bit);
      cyc(5);
      chk(run_out[0], 1'b0);
      gate_a <= 1'b1;
      wait_run(1'b1, 5, c);
      c0 = run_cnt;
      cyc(40);
      chk(run_cnt - c0, 40);
      gate_a <= 1'b0;
      wait_run(1'b0, 5, c);
      wr(`OFS_CTRL_A, gate_m | low_bit | run_bit);
      wait_run(1'b1, 5, c);
      gate_a <= 1'b1;
      wait_run(1'b0, 5, c);
   endtask
   initial begin
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, gate_a, gate_b} = 7'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      s_reset();
      s_map();
      s_single();
      s_cont();
      s_ext();
      s_gate();
      tally_and_finish();
   end
endmodule
